/* File: lcdc_pkg.sv */
package lcdc_pkg;

  localparam int ADDR_W  = 4;
  localparam int DATA_W  = 8;
  localparam int FP_REGS = 6;
  localparam int NUM_BP  = 4;

  // Register offsets
  localparam logic [3:0] OFF_CLK_SEL   = 4'h0;
  localparam logic [3:0] OFF_SUPPLY    = 4'h1;
  localparam logic [3:0] OFF_LOWPWR    = 4'h2;
  localparam logic [3:0] OFF_TIMING    = 4'h3;
  localparam logic [3:0] OFF_BLINK     = 4'h4;
  localparam logic [3:0] OFF_FPEN0     = 4'h5;
  localparam logic [3:0] OFF_FPEN_LAST = 4'ha;
  localparam logic [3:0] OFF_STATUS    = 4'hb;

  // Field positions
  localparam int CS_SOURCE_BIT   = 7;
  localparam int CS_PRESCALE_BY_SIXTEEN_BIT    = 6;
  localparam int SUP_PUMP_ON_BIT = 7;
  localparam int SUP_TRIPLER_BIT = 6;
  localparam int SUP_STRONG_BIT  = 5;
  localparam int SUP_PCLK_LSB    = 3;
  localparam int SUP_SKIP_BIT    = 2;
  localparam int SUP_SEL_LSB     = 0;
  localparam int LP_WAIT_DIS_BIT = 1;
  localparam int LP_STOP_DIS_BIT = 0;
  localparam int TM_ENABLE_BIT   = 7;
  localparam int TM_FRAME_LSB    = 3;
  localparam int TM_LOW_POWER_WAVEFORM_BIT_BIT   = 2;
  localparam int TM_DUTY_LSB     = 0;
  localparam int BL_ENABLE_BIT   = 7;
  localparam int BL_SCOPE_BIT    = 3;
  localparam int BL_RATE_LSB     = 0;

  // Writable bits; the rest read as zero
  localparam logic [7:0] LOWPWR_MASK = 8'h03;
  localparam logic [7:0] TIMING_MASK = 8'hbf;
  localparam logic [7:0] BLINK_MASK  = 8'h8f;

  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // Encodings
  localparam logic [1:0] SUPPLY_GEN_REF2 = 2'b00;
  localparam logic [1:0] SUPPLY_GEN_REF3 = 2'b01;
  localparam logic [1:0] SUPPLY_EXT_PIN  = 2'b10;
  localparam logic [1:0] DUTY_THIRD      = 2'b10;
  localparam logic [1:0] DUTY_QUARTER    = 2'b11;
  localparam logic [3:0] PRE16_LAST      = 4'hf;

  typedef enum logic [2:0] {
    RUN_OFF   = 3'b001,
    RUN_ON    = 3'b010,
    RUN_SLEEP = 3'b100
  } lcdc_run_e;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } lcdc_bus_req_s;

  typedef struct packed {
    logic       pump_on;
    logic       pump_tripler;
    logic       strong_buffer;
    logic [1:0] pump_clock_source;
    logic       buffer_skip;
    logic       gen_ref2;
    logic       gen_ref3;
    logic       ext_supply;
  } lcdc_supply_s;

  typedef struct packed {
    lcdc_run_e             run;
    logic [7:0]            clk_sel;
    logic [7:0]            supply;
    logic [7:0]            lowpwr;
    logic [7:0]            timing;
    logic [7:0]            blink;
    logic [FP_REGS-1:0][7:0] fpen;
    logic [7:0]            rdata;
    logic [5:0]            pre_cnt;
    logic [3:0]            div_cnt;
    logic [7:0]            phase_cnt;
    logic [1:0]            bp_idx;
    logic [1:0]            act_duty;
    logic [2:0]            act_frame;
    logic                  act_low_power_waveform_bit;
    logic                  frame_par;
    logic [15:0]           blink_cnt;
    logic                  blink_off;
  } lcdc_state_s;

endpackage

/* File: lcdc_driver.sv */
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module lcdc_driver #(
  parameter int NUM_FP      = 48,
  parameter int BLINK_SHIFT = 4
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst_n,
  input  wire lcdc_pkg::lcdc_bus_req_s      i_bus,
  output logic [7:0]                        o_rdata,
  input  wire logic                         i_ext_ref_tick,
  input  wire logic                         i_wait_mode,
  input  wire logic                         i_deep_sleep_level_three_mode,
  input  wire logic [NUM_FP-1:0][3:0]       i_seg_on,
  input  wire logic [NUM_FP-1:0]            i_seg_blink_sel,
  output logic [3:0]                        o_bp_level,
  output logic [3:0]                        o_bp_oe,
  output logic [NUM_FP-1:0]                 o_fp_level,
  output logic [NUM_FP-1:0]                 o_fp_oe,
  output lcdc_pkg::lcdc_supply_s            o_supply
);

  function automatic logic [2:0] bp_count(input logic [1:0] duty);
    bp_count = {1'b0, duty} + 3'h1;
  endfunction

  function automatic logic [7:0] phase_last(input logic [2:0] frame);
    phase_last = (8'h01 << frame) - 8'h01;
  endfunction

  function automatic logic [15:0] blink_last(input logic [2:0] rate);
    blink_last = (16'h0001 << (5'(rate) + 5'(BLINK_SHIFT))) - 16'h0001;
  endfunction

  lcdc_pkg::lcdc_state_s q;
  lcdc_pkg::lcdc_state_s d;

  logic              src_tick;
  logic              pre_wrap;
  logic              base_tick;
  logic              lcd_on;
  logic              sleep_req;
  logic              phase_end;
  logic              frame_end;
  logic              pol;
  logic [47:0]       fpen_flat;
  logic [2:0]        fp_sel;

  assign src_tick  = q.clk_sel[lcdc_pkg::CS_SOURCE_BIT] ? 1'b1 : i_ext_ref_tick;
  // adjust then optional /16
  // Compare with >= so a smaller new adjust wraps at once, not after 64 counts
  assign pre_wrap  = src_tick && (q.pre_cnt >= q.clk_sel[5:0]);
  assign base_tick = pre_wrap && (!q.clk_sel[lcdc_pkg::CS_PRESCALE_BY_SIXTEEN_BIT]
                                  || q.div_cnt == lcdc_pkg::PRE16_LAST);
  assign lcd_on    = (q.run == lcdc_pkg::RUN_ON);
  assign sleep_req = (i_wait_mode && q.lowpwr[lcdc_pkg::LP_WAIT_DIS_BIT])
                  || (i_deep_sleep_level_three_mode && q.lowpwr[lcdc_pkg::LP_STOP_DIS_BIT]);
  assign phase_end = lcd_on && base_tick && (q.phase_cnt == phase_last(q.act_frame));
  assign frame_end = phase_end && ({1'b0, q.bp_idx} == bp_count(q.act_duty) - 3'h1);
  assign pol       = q.act_low_power_waveform_bit ? q.frame_par : (q.frame_par ^ q.bp_idx[0]);
  assign fpen_flat = q.fpen;
  assign fp_sel    = 3'(i_bus.addr - lcdc_pkg::OFF_FPEN0);

  always_comb
  begin
    d = q;
    d.rdata = 8'h00;

    if (i_bus.wr)
    begin
      if (i_bus.addr == lcdc_pkg::OFF_CLK_SEL)
        d.clk_sel = i_bus.wdata;
      else if (i_bus.addr == lcdc_pkg::OFF_SUPPLY)
        d.supply = i_bus.wdata;
      else if (i_bus.addr == lcdc_pkg::OFF_LOWPWR)
        d.lowpwr = i_bus.wdata & lcdc_pkg::LOWPWR_MASK;
      else if (i_bus.addr == lcdc_pkg::OFF_TIMING)
        d.timing = i_bus.wdata & lcdc_pkg::TIMING_MASK;
      else if (i_bus.addr == lcdc_pkg::OFF_BLINK)
        d.blink = i_bus.wdata & lcdc_pkg::BLINK_MASK;
      else if (i_bus.addr >= lcdc_pkg::OFF_FPEN0 && i_bus.addr <= lcdc_pkg::OFF_FPEN_LAST)
        d.fpen[fp_sel] = i_bus.wdata;
    end

    if (i_bus.rd)
    begin
      if (i_bus.addr == lcdc_pkg::OFF_CLK_SEL)
        d.rdata = q.clk_sel;
      else if (i_bus.addr == lcdc_pkg::OFF_SUPPLY)
        d.rdata = q.supply;
      else if (i_bus.addr == lcdc_pkg::OFF_LOWPWR)
        d.rdata = q.lowpwr;
      else if (i_bus.addr == lcdc_pkg::OFF_TIMING)
        d.rdata = q.timing;
      else if (i_bus.addr == lcdc_pkg::OFF_BLINK)
        d.rdata = q.blink;
      else if (i_bus.addr >= lcdc_pkg::OFF_FPEN0 && i_bus.addr <= lcdc_pkg::OFF_FPEN_LAST)
        d.rdata = q.fpen[fp_sel];
      else if (i_bus.addr == lcdc_pkg::OFF_STATUS)
        d.rdata = {lcd_on, q.run == lcdc_pkg::RUN_SLEEP, q.blink_off, q.frame_par,
                   2'b00, q.bp_idx};
    end

    // Prescaler runs regardless of display state
    if (src_tick)
    begin
      if (pre_wrap)
      begin
        d.pre_cnt = 6'h00;
        d.div_cnt = q.div_cnt + 4'h1;
      end
      else
        d.pre_cnt = q.pre_cnt + 6'h01;
    end

    case (q.run)
      lcdc_pkg::RUN_OFF:
      begin
        if (q.timing[lcdc_pkg::TM_ENABLE_BIT] && !sleep_req)
        begin
          d.run        = lcdc_pkg::RUN_ON;
          d.phase_cnt  = 8'h00;
          d.bp_idx     = 2'b00;
          d.frame_par  = 1'b0;
          d.act_duty   = q.timing[1:0];
          d.act_frame  = q.timing[5:3];
          d.act_low_power_waveform_bit = q.timing[lcdc_pkg::TM_LOW_POWER_WAVEFORM_BIT_BIT];
        end
      end
      lcdc_pkg::RUN_ON:
      begin
        if (!q.timing[lcdc_pkg::TM_ENABLE_BIT])
          d.run = lcdc_pkg::RUN_OFF;
        else if (sleep_req)
          d.run = lcdc_pkg::RUN_SLEEP;
      end
      lcdc_pkg::RUN_SLEEP:
      begin
        // Resumes mid-frame; counters were frozen
        if (!q.timing[lcdc_pkg::TM_ENABLE_BIT])
          d.run = lcdc_pkg::RUN_OFF;
        else if (!sleep_req)
          d.run = lcdc_pkg::RUN_ON;
      end
      default:
        d.run = lcdc_pkg::RUN_OFF;
    endcase

    if (lcd_on && base_tick)
    begin
      if (phase_end)
      begin
        d.phase_cnt = 8'h00;
        d.bp_idx    = q.bp_idx + 2'b01;
      end
      else
        d.phase_cnt = q.phase_cnt + 8'h01;
    end

    if (frame_end)
    begin
      d.bp_idx     = 2'b00;
      d.frame_par  = ~q.frame_par;
      d.act_duty   = q.timing[1:0];
      d.act_frame  = q.timing[5:3];
      d.act_low_power_waveform_bit = q.timing[lcdc_pkg::TM_LOW_POWER_WAVEFORM_BIT_BIT];
    end

    if (!q.blink[lcdc_pkg::BL_ENABLE_BIT])
    begin
      d.blink_cnt = 16'h0000;
      d.blink_off = 1'b0;
    end
    else if (lcd_on && base_tick)
    begin
      if (q.blink_cnt >= blink_last(q.blink[2:0]))
      begin
        d.blink_cnt = 16'h0000;
        d.blink_off = ~q.blink_off;
      end
      else
        d.blink_cnt = q.blink_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      q.run        <= lcdc_pkg::RUN_OFF;
      q.clk_sel    <= lcdc_pkg::RST_REG;
      q.supply     <= lcdc_pkg::RST_REG;
      q.lowpwr     <= lcdc_pkg::RST_REG;
      q.timing     <= lcdc_pkg::RST_REG;
      q.blink      <= lcdc_pkg::RST_REG;
      q.fpen       <= '0;
      q.rdata      <= 8'h00;
      q.pre_cnt    <= 6'h00;
      q.div_cnt    <= 4'h0;
      q.phase_cnt  <= 8'h00;
      q.bp_idx     <= 2'b00;
      q.act_duty   <= 2'b00;
      q.act_frame  <= 3'b000;
      q.act_low_power_waveform_bit <= 1'b0;
      q.frame_par  <= 1'b0;
      q.blink_cnt  <= 16'h0000;
      q.blink_off  <= 1'b0;
    end
    else
      q <= d;
  end

  assign o_rdata = q.rdata;

  always_comb
  begin
    for (int i = 0; i < lcdc_pkg::NUM_BP; i++)
    begin
      o_bp_oe[i]    = lcd_on && (3'(i) < bp_count(q.act_duty));
      o_bp_level[i] = lcd_on && ((q.bp_idx == 2'(i)) ^ pol);
    end
  end

  always_comb
  begin
    for (int j = 0; j < NUM_FP; j++)
    begin
      o_fp_oe[j]    = lcd_on && fpen_flat[j];
      o_fp_level[j] = lcd_on && ((i_seg_on[j][q.bp_idx]
                      && !(q.blink_off && (q.blink[lcdc_pkg::BL_SCOPE_BIT]
                      || i_seg_blink_sel[j]))) ^ pol);
    end
  end

  always_comb
  begin
    o_supply.pump_on           = q.supply[lcdc_pkg::SUP_PUMP_ON_BIT];
    o_supply.pump_tripler      = q.supply[lcdc_pkg::SUP_TRIPLER_BIT];
    o_supply.strong_buffer     = q.supply[lcdc_pkg::SUP_STRONG_BIT];
    o_supply.pump_clock_source = q.supply[4:3];
    o_supply.buffer_skip       = q.supply[lcdc_pkg::SUP_SKIP_BIT];
    o_supply.gen_ref2          = (q.supply[1:0] == lcdc_pkg::SUPPLY_GEN_REF2);
    o_supply.gen_ref3          = (q.supply[1:0] == lcdc_pkg::SUPPLY_GEN_REF3);
    o_supply.ext_supply        = (q.supply[1:0] == lcdc_pkg::SUPPLY_EXT_PIN);
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_wr_supply;
    i_bus.wr && i_bus.addr == lcdc_pkg::OFF_SUPPLY;
  endsequence

  sequence s_wr_timing;
    i_bus.wr && i_bus.addr == lcdc_pkg::OFF_TIMING;
  endsequence

  property p_bus_source;
    q.clk_sel == 8'h80 |-> base_tick;
  endproperty
  a_bus_source: assert property (p_bus_source)
    else $error("bus source with no prescale must tick every cycle");

  property p_ext_source;
    !q.clk_sel[lcdc_pkg::CS_SOURCE_BIT] && !i_ext_ref_tick |-> !base_tick;
  endproperty
  a_ext_source: assert property (p_ext_source)
    else $error("external source ticked without reference");

  property p_prescale_by_sixteen;
    base_tick && q.clk_sel[lcdc_pkg::CS_PRESCALE_BY_SIXTEEN_BIT] |-> q.div_cnt == 4'hf;
  endproperty
  a_prescale_by_sixteen: assert property (p_prescale_by_sixteen)
    else $error("divide by sixteen skipped");

  property p_pump;
    s_wr_supply |=> o_supply.pump_on == $past(i_bus.wdata[7])
                    && o_supply.pump_tripler == $past(i_bus.wdata[6]);
  endproperty
  a_pump: assert property (p_pump)
    else $error("pump controls do not follow write");

  property p_skip;
    s_wr_supply |=> o_supply.buffer_skip == $past(i_bus.wdata[2])
                    && o_supply.pump_clock_source == $past(i_bus.wdata[4:3]);
  endproperty
  a_skip: assert property (p_skip)
    else $error("buffer skip or pump clock mismatch");

  property p_ref3;
    s_wr_supply and i_bus.wdata[1:0] == 2'b01 |=> o_supply.gen_ref3 && !o_supply.ext_supply;
  endproperty
  a_ref3: assert property (p_ref3)
    else $error("supply 01 did not select internal third level");

  property p_stop_off;
    i_deep_sleep_level_three_mode && q.lowpwr[0] |=> o_bp_oe == 4'h0;
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("display still driven in deep_sleep_level_three");

  property p_wait_on;
    lcd_on && i_wait_mode && !q.lowpwr[1] && !i_deep_sleep_level_three_mode
      && q.timing[7] |=> o_bp_oe[0];
  endproperty
  a_wait_on: assert property (p_wait_on)
    else $error("display dropped in wait mode");

  property p_third;
    lcd_on && q.act_duty == 2'b10 |-> o_bp_oe == 4'b0111;
  endproperty
  a_third: assert property (p_third)
    else $error("one-third duty must drive three backplanes");

  property p_quarter;
    lcd_on && q.act_duty == 2'b11 |-> o_bp_oe == 4'b1111;
  endproperty
  a_quarter: assert property (p_quarter)
    else $error("one-quarter duty must drive four backplanes");

  property p_frame_sync;
    s_wr_timing ##0 !frame_end ##1 !frame_end && q.run != lcdc_pkg::RUN_OFF
      |=> $stable(q.act_duty) && $stable(q.act_frame);
  endproperty
  a_frame_sync: assert property (p_frame_sync)
    else $error("timing applied off frame boundary");

  property p_phase_len;
    phase_end && q.act_frame == 3'b011 |-> q.phase_cnt == 8'h07;
  endproperty
  a_phase_len: assert property (p_phase_len)
    else $error("frame field 011 phase length wrong");

  property p_low_power_waveform_bit;
    lcd_on && q.act_low_power_waveform_bit && !frame_end |=> $stable(pol);
  endproperty
  a_low_power_waveform_bit: assert property (p_low_power_waveform_bit)
    else $error("low-power waveform changed polarity mid-frame");

  property p_blink_all;
    lcd_on && q.blink_off && q.blink[3] |-> o_fp_level == {NUM_FP{pol}};
  endproperty
  a_blink_all: assert property (p_blink_all)
    else $error("blink all left a segment lit");

  property p_fpen;
    i_bus.wr && i_bus.addr == lcdc_pkg::OFF_FPEN0 ##1 lcd_on |-> o_fp_oe[7:0] == $past(i_bus.wdata);
  endproperty
  a_fpen: assert property (p_fpen)
    else $error("frontplane enable not applied");

endmodule

/* File: lcdc_glass.sv */
`timescale 1ns/10ps
// Passive glass model: loads the pins, records which backplanes were
// driven and the shortest spacing between backplane level changes.
module lcdc_glass (
  input  wire logic       i_ref_clk,
  input  wire logic       i_clear,
  input  wire logic [3:0] i_bp_level,
  input  wire logic [3:0] i_bp_oe,
  output logic [3:0]      o_bp_seen,
  output logic [7:0]      o_min_gap
);
  logic [3:0] last_q;
  logic [7:0] cnt_q;
  logic       armed_q;

  always_ff @(posedge i_ref_clk)
  begin
    last_q <= i_bp_level;
    if (i_clear)
    begin
      o_bp_seen <= 4'h0;
      o_min_gap <= 8'hff;
      armed_q   <= 1'b0;
      cnt_q     <= 8'h00;
    end
    else
    begin
      o_bp_seen <= o_bp_seen | i_bp_oe;
      if (i_bp_level !== last_q)
      begin
        if (armed_q && cnt_q < o_min_gap)
          o_min_gap <= cnt_q;
        armed_q <= 1'b1;
        cnt_q   <= 8'h01;
      end
      else if (cnt_q != 8'hff)
        cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
  logic                     i_ref_clk;
  logic                     i_rst_n;
  lcdc_pkg::lcdc_bus_req_s  bus;
  lcdc_pkg::lcdc_supply_s   sup;
  logic [7:0]               rdata;
  logic                     ext;
  logic                     ext_en;
  logic                     wt;
  logic                     st;
  logic [3:0]               bpl;
  logic [3:0]               bpo;
  logic [47:0]              fpl;
  logic [47:0]              fpo;
  logic [47:0][3:0]         seg;
  logic [47:0]              bsel;
  logic                     clr;
  logic [3:0]               seen;
  logic [7:0]               gap;
  logic [7:0]               shadow [16];
  logic [7:0]               d;
  int                       tc;
  int                       mismatches;
  int                       compares;

  lcdc_driver #(.NUM_FP(48), .BLINK_SHIFT(0)) DUT (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_ext_ref_tick(ext), .i_wait_mode(wt), .i_deep_sleep_level_three_mode(st), .i_seg_on(seg),
    .i_seg_blink_sel(bsel), .o_bp_level(bpl), .o_bp_oe(bpo), .o_fp_level(fpl),
    .o_fp_oe(fpo), .o_supply(sup));

  lcdc_glass glass (.i_ref_clk(i_ref_clk), .i_clear(clr), .i_bp_level(bpl),
    .i_bp_oe(bpo), .o_bp_seen(seen), .o_min_gap(gap));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  // External reference: one tick every third cycle
  always @(posedge i_ref_clk)
  begin
    tc  <= (tc == 2) ? 0 : tc + 1;
    ext <= ext_en && (tc == 2);
  end

  function automatic logic [7:0] regv(input int a, input logic [7:0] v);
    case (a)
      2:       return v & lcdc_pkg::LOWPWR_MASK;
      3:       return v & lcdc_pkg::TIMING_MASK;
      4:       return v & lcdc_pkg::BLINK_MASK;
      default: return (a < 11) ? v : 8'h00;
    endcase
  endfunction

  function automatic logic [8:0] exp_sup(input logic [7:0] v);
    return {v[7:2], v[1:0] == 2'b00, v[1:0] == 2'b01, v[1:0] == 2'b10};
  endfunction

  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input int a, input logic [7:0] v);
    @(posedge i_ref_clk);
    bus <= '{addr: 4'(a), wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge i_ref_clk);
    bus <= '0;
    shadow[a] = regv(a, v);
  endtask

  task automatic rd(input int a, input logic [7:0] e);
    @(posedge i_ref_clk);
    bus <= '{addr: 4'(a), wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_ref_clk);
    bus <= '0;
    @(negedge i_ref_clk);
    chk(48'(rdata), 48'(e));
  endtask

  // Settle past a frame boundary, then measure a clean window
  task automatic show(input logic [7:0] cs, input logic [7:0] tim,
                      input logic [3:0] es, input logic [7:0] eg);
    wr(0, cs);
    wr(3, tim);
    repeat (150) @(posedge i_ref_clk);
    clr <= 1'b1;
    @(posedge i_ref_clk);
    clr <= 1'b0;
    repeat (200) @(posedge i_ref_clk);
    chk(48'(seen), 48'(es));
    if (eg != 8'h00)
      chk(48'(gap), 48'(eg));
    chk(fpo, {shadow[10], shadow[9], shadow[8], shadow[7], shadow[6], shadow[5]});
  endtask

  task automatic slp(input logic [7:0] lp, input logic w, input logic s, input logic on);
    wr(2, lp);
    wt <= w;
    st <= s;
    repeat (4) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(48'(|bpo), 48'(on));
    if (!on)
      chk(fpo, 48'h0);
  endtask

  // Every complete run of the watched level must last len cycles.
  // Segment 0 is never lit, so its level is the unlit reference.
  task automatic runs(input logic lp, input int len, input logic [47:0] dark);
    logic [47:0] lit;
    logic [47:0] vis;
    logic        cur;
    logic        prev;
    int          run;
    int          nrun;
    lit  = '0;
    prev = 1'b0;
    run  = 0;
    nrun = 0;
    for (int j = 1; j < 48; j++)
      lit[j] = seg[j][0];
    repeat (20) @(posedge i_ref_clk);
    for (int i = 0; i < 10 * len; i++)
    begin
      @(negedge i_ref_clk);
      vis = fpl ^ {48{fpl[0]}};
      cur = lp ? bpl[3] : (vis !== lit);
      if (!lp && cur)
        chk(vis, lit & ~dark);
      if (i > 0 && cur != prev)
      begin
        if (nrun > 0)
          chk(48'(run), 48'(len));
        nrun++;
        run = 0;
      end
      run++;
      prev = cur;
    end
    chk(48'(nrun > 3), 48'h1);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge i_ref_clk);
    mismatches++;
    end_sim();
  end

  initial
  begin
    bus = '0;
    ext = 1'b0;
    ext_en = 1'b0;
    tc = 0;
    wt = 1'b0;
    st = 1'b0;
    clr = 1'b1;
    seg = '0;
    bsel = '0;
    i_rst_n = 1'b0;
    mismatches = 0;
    compares = 0;
    void'($urandom(32'he871));
    repeat (16) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    for (int j = 0; j < 48; j++)
      seg[j] <= 4'($urandom);
    bsel <= 48'({$urandom, $urandom});
    // Corner: reference segment kept dark
    seg[0] <= 4'h0;
    for (int a = 0; a < 16; a++)
      rd(a, 8'h00);
    @(negedge i_ref_clk);
    chk(48'(sup), 48'(exp_sup(8'h00)));
    chk(48'(bpo), 48'h0);
    // Random fill, including unmapped places; status is read only
    for (int a = 0; a < 16; a++)
      if (a != 11)
        wr(a, 8'($urandom));
    for (int a = 0; a < 16; a++)
      if (a != 11)
        rd(a, shadow[a]);
    for (int s = 0; s < 4; s++)
    begin
      d = {6'($urandom), 2'(s)};
      wr(1, d);
      @(negedge i_ref_clk);
      chk(48'(sup), 48'(exp_sup(d)));
    end
    wr(2, 8'h00);
    wr(4, 8'h00);
    // Stop the random setup so the next enable latches timing at once
    wr(3, 8'h00);
    for (int k = 0; k < 4; k++)
      show(8'h80, 8'h80 | 8'(k), 4'((1 << (k + 1)) - 1), (k == 0) ? 8'h00 : 8'h01);
    show(8'h82, 8'h83, 4'hf, 8'h03);
    show(8'hc0, 8'h83, 4'hf, 8'h10);
    show(8'h80, 8'h93, 4'hf, 8'h04);
    show(8'h80, 8'h9a, 4'h7, 8'h08);
    show(8'h81, 8'h8f, 4'hf, 8'h04);
    ext_en <= 1'b1;
    show(8'h00, 8'h83, 4'hf, 8'h03);
    ext_en <= 1'b0;
    show(8'h00, 8'h83, 4'hf, 8'hff);
    wr(0, 8'h80);
    slp(8'h01, 1'b0, 1'b1, 1'b0);
    slp(8'h01, 1'b1, 1'b0, 1'b1);
    slp(8'h02, 1'b1, 1'b0, 1'b0);
    slp(8'h02, 1'b0, 1'b1, 1'b1);
    slp(8'h00, 1'b0, 1'b0, 1'b1);
    wr(3, 8'h85);
    runs(1'b1, 2, '0);
    wr(3, 8'h80);
    wr(4, 8'h8c);
    runs(1'b0, 16, '1);
    wr(4, 8'h82);
    runs(1'b0, 4, bsel);
    end_sim();
  end
endmodule
